/* File: dsx_defs.vh */
// constants for the deep-sleep exit and retention controller
// assumes one 20 MHz clock and a plain strobe register port
// Functional notes
// - exit on por, watchdog, alarm, clear pin, wake
// - wake input exits only on edge to polarity
// - pending interrupts discarded at deep sleep entry
// - wake acts as por, keeps calendar, scratch, flag
// - wake events during por sequence are ignored
// - exit clears arm bit, restarts at reset vector
// - exit flag at bit 10, software clears
// - brown-out in sleep recorded at control bit 1
// - scratch registers retained through wake reset
// - pins held at entry state during sleep
// - held pins ignore new direction and latch
// - release clear hands pins to settings
// - brown-out or por releases pins, drops retention
// - clear pin keeps retained regs and release
// - watchdog enable config bit 7, reset on entry
// - watchdog clock bit 4, postscaler bits 3:0
// - calendar clock select at config bit 5
// - watchdog source clock started automatically
// - arm cleared if no power save in four cycles
// - setting arm clears every wake-source flag
// - release one holds oscillator, and pins except after a clear-pin wake
`ifndef DSX_DEFS_VH
`define DSX_DEFS_VH
`define DSX_A_CTRL      4'h0
`define DSX_A_WAKE      4'h1
`define DSX_A_RST       4'h2
`define DSX_A_GPR0      4'h3
`define DSX_A_GPR1      4'h4
`define DSX_A_CFG       4'h5
`define DSX_A_DIR       4'h6
`define DSX_A_LAT       4'h7
`define DSX_A_CMD       4'h8
`define DSX_A_STAT      4'h9
`define DSX_B_ARM       15
`define DSX_B_BOR       1
`define DSX_B_REL       0
`define DSX_B_EXIT      10
`define DSX_B_POR       0
`define DSX_W_WAKE      8
`define DSX_W_FLT       7
`define DSX_W_WDT       4
`define DSX_W_RTC       3
`define DSX_W_MASTER_CLEAR_PIN      2
`define DSX_W_POR       0
`define DSX_C_WDTEN     7
`define DSX_C_CALENDAR_CLOCK_SELECT    5
`define DSX_C_WDTOSC    4
`define DSX_C_CFGRST    8'h00
`define DSX_ARM_WIN     3
`define DSX_POR_NS      1000
`define DSX_POR_CYC     ((`DSX_POR_NS + 49) / 50)
`define DSX_WDT_BASE    42000
`endif

/* File: dsx_ctrl.v */
// deep-sleep entry, wake, reset sequence and pin/register retention
// assumes pin and oscillator inputs are asynchronous; bus is on sys_clk
//
// The placing of the registers and strobed register access were chosen for this implementation.
`include "dsx_defs.vh"
module dsx_ctrl #(
   parameter NPIN     = 8,
   parameter WDT_BASE = `DSX_WDT_BASE
) (
   sys_clk,
   arst_n,
   bus_addr,
   bus_wdata,
   bus_wr,
   bus_rd,
   bus_rdata,
   power_save,
   irq_pending,
   irq_discard,
   sleeping,
   cpu_reset,
   secondary_oscillator_run,
   low_power_rc_clock_run,
   secondary_oscillator_enable,
   calendar_alarm,
   master_clear_n,
   external_wake_input,
   wake_polarity,
   wake_enable,
   brownout_event,
   supply_por,
   calendar_enable,
   pin_out,
   pin_oe
);
   input  wire              sys_clk;
   input  wire              arst_n;
   input  wire [3:0]        bus_addr;
   input  wire [15:0]       bus_wdata;
   input  wire              bus_wr;
   input  wire              bus_rd;
   output reg  [15:0]       bus_rdata;
   input  wire              power_save;
   input  wire              irq_pending;
   output wire              irq_discard;
   output wire              sleeping;
   output wire              cpu_reset;
   output wire              secondary_oscillator_run;
   output wire              low_power_rc_clock_run;
   output wire              secondary_oscillator_enable;
   input  wire              calendar_alarm;
   input  wire              master_clear_n;
   input  wire              external_wake_input;
   input  wire              wake_polarity;
   input  wire              wake_enable;
   input  wire              brownout_event;
   input  wire              supply_por;
   input  wire              calendar_enable;
   output wire [NPIN-1:0]   pin_out;
   output wire [NPIN-1:0]   pin_oe;

   localparam ST_RUN   = 2'd0;
   localparam ST_SLEEP = 2'd1;
   localparam ST_POR   = 2'd2;
   localparam ST_DEF   = 2'd3;

   // async inputs through two flops
   localparam NS = 6;
   wire [NS-1:0] raw_in = {calendar_alarm, master_clear_n, external_wake_input,
                           brownout_event, supply_por, secondary_oscillator_enable};
   reg  [NS-1:0] sy1_r;
   reg  [NS-1:0] sy2_r;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         // clear pin idles high, so no false clear follows reset
         sy1_r <= 6'h10;
         sy2_r <= 6'h10;
      end else begin
         sy1_r <= raw_in;
         sy2_r <= sy1_r;
      end
   end
   wire s_alarm = sy2_r[5];
   wire s_master_clear_pin  = ~sy2_r[4];
   wire s_wake  = sy2_r[3];
   wire s_bor   = sy2_r[2];
   wire s_por   = sy2_r[1];

   reg  [1:0]        st_r;
   reg  [1:0]        st_nxt;
   reg               arm_r;
   reg  [1:0]        arm_cnt_r;
   reg               bor_r;
   reg               rel_r;
   reg               exit_r;
   reg               porf_r;
   reg  [8:0]        wake_r;
   reg  [15:0]       gpr0_r;
   reg  [15:0]       gpr1_r;
   reg  [7:0]        cfg_r;
   reg  [NPIN-1:0]   dir_r;
   reg  [NPIN-1:0]   lat_r;
   reg  [NPIN-1:0]   hdir_r;
   reg  [NPIN-1:0]   hlat_r;
   reg               secondary_oscillator_en_r;
   reg               hsosc_r;
   reg               wake_prev_r;
   reg               wake_armed_r;
   reg               master_clear_pin_sleep_r;
   reg  [15:0]       por_cnt_r;
   reg  [47:0]       wdt_cnt_r;
   reg               wdt_clk_ok_r;

   wire wr_ctrl = bus_wr && (bus_addr == `DSX_A_CTRL);
   wire arm_set = wr_ctrl && bus_wdata[`DSX_B_ARM] && !arm_r;
   wire enter   = (st_r == ST_RUN) && power_save && arm_r;
   wire wdt_en  = cfg_r[`DSX_C_WDTEN];
   wire [47:0] wdt_limit = (48'd1 << cfg_r[3:0]) * WDT_BASE;
   wire wdt_to  = wdt_en && wdt_clk_ok_r && (wdt_cnt_r >= wdt_limit);
   wire wake_hit = wake_armed_r && (s_wake == wake_polarity) && (wake_prev_r != wake_polarity);
   wire alarm_hit = s_alarm && calendar_enable;
   wire any_exit = s_por || wdt_to || alarm_hit || s_master_clear_pin || wake_hit || (s_bor && cfg_r[6]);
   wire lost     = s_por || (s_bor && cfg_r[6]);

   always @* begin
      case (st_r)
         ST_RUN:   st_nxt = enter ? ST_SLEEP : ST_RUN;
         ST_SLEEP: st_nxt = any_exit ? ST_POR : ST_SLEEP;
         ST_POR:   st_nxt = (por_cnt_r == `DSX_POR_CYC) ? ST_RUN : ST_POR;
         default:  st_nxt = ST_RUN;
      endcase
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= ST_RUN;
         arm_r <= 1'b0;
         arm_cnt_r <= 2'd0;
         bor_r <= 1'b0;
         rel_r <= 1'b0;
         exit_r <= 1'b0;
         porf_r <= 1'b1;
         wake_r <= 9'h000;
         gpr0_r <= 16'h0000;
         gpr1_r <= 16'h0000;
         cfg_r <= `DSX_C_CFGRST;
         dir_r <= {NPIN{1'b1}};
         lat_r <= {NPIN{1'b0}};
         hdir_r <= {NPIN{1'b1}};
         hlat_r <= {NPIN{1'b0}};
         secondary_oscillator_en_r <= 1'b0;
         hsosc_r <= 1'b0;
         wake_prev_r <= 1'b0;
         wake_armed_r <= 1'b0;
         master_clear_pin_sleep_r <= 1'b0;
         por_cnt_r <= 16'h0000;
         wdt_cnt_r <= 48'h0;
         wdt_clk_ok_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         wake_prev_r <= s_wake;
         por_cnt_r <= (st_r == ST_POR) ? por_cnt_r + 16'h0001 : 16'h0000;
         // arm window counts cycles after the set
         if (arm_set) begin
            arm_r <= 1'b1;
            arm_cnt_r <= 2'd0;
            wake_r <= 9'h000;
         end else if (arm_r && st_r == ST_RUN && !enter) begin
            if (arm_cnt_r == `DSX_ARM_WIN) arm_r <= 1'b0;
            else arm_cnt_r <= arm_cnt_r + 2'd1;
         end
         if (enter) begin
            hdir_r <= dir_r;
            hlat_r <= lat_r;
            hsosc_r <= secondary_oscillator_en_r;
            rel_r <= 1'b1;
            wake_armed_r <= wake_enable;
            master_clear_pin_sleep_r <= 1'b0;
            wdt_cnt_r <= 48'h0;
            wdt_clk_ok_r <= 1'b0;
            bor_r <= 1'b0;
         end
         if (st_r == ST_SLEEP) begin
            wdt_clk_ok_r <= 1'b1;
            if (wdt_en && wdt_clk_ok_r) wdt_cnt_r <= wdt_cnt_r + 48'h1;
            if (s_bor) bor_r <= 1'b1;
            // each cause sticky on its own bit
            if (wake_hit) wake_r[`DSX_W_WAKE] <= 1'b1;
            if (wdt_to) wake_r[`DSX_W_WDT] <= 1'b1;
            if (alarm_hit) wake_r[`DSX_W_RTC] <= 1'b1;
            if (s_master_clear_pin) begin
               wake_r[`DSX_W_MASTER_CLEAR_PIN] <= 1'b1;
               master_clear_pin_sleep_r <= 1'b1;
            end
            if (s_por) wake_r[`DSX_W_POR] <= 1'b1;
         end
         if (st_r == ST_SLEEP && any_exit) begin
            arm_r <= 1'b0;
            exit_r <= 1'b1;
            // por-like reset of ordinary registers; scratch kept except on a por or brown-out exit
            dir_r <= {NPIN{1'b1}};
            lat_r <= {NPIN{1'b0}};
            secondary_oscillator_en_r <= 1'b0;
            porf_r <= 1'b1;
            if (lost) begin
               rel_r <= 1'b0;
               gpr0_r <= 16'h0000;
               gpr1_r <= 16'h0000;
            end
         end
         // register writes; wake flags are hardware-set only, software may clear
         if (bus_wr && st_r == ST_RUN) begin
            case (bus_addr)
               `DSX_A_CTRL: if (!bus_wdata[`DSX_B_REL]) rel_r <= 1'b0;
               `DSX_A_WAKE: if (!arm_set) wake_r <= wake_r & bus_wdata[8:0];
               `DSX_A_RST: begin
                  if (!bus_wdata[`DSX_B_EXIT]) exit_r <= 1'b0;
                  if (!bus_wdata[`DSX_B_POR]) porf_r <= 1'b0;
               end
               `DSX_A_GPR0: gpr0_r <= bus_wdata;
               `DSX_A_GPR1: gpr1_r <= bus_wdata;
               `DSX_A_CFG: cfg_r <= bus_wdata[7:0];
               `DSX_A_DIR: dir_r <= bus_wdata[NPIN-1:0];
               `DSX_A_LAT: lat_r <= bus_wdata[NPIN-1:0];
               `DSX_A_CMD: secondary_oscillator_en_r <= bus_wdata[0];
               default: ;
            endcase
         end
      end
   end

   // events during por sequence never reach flags since they gate on sleep state
   assign cpu_reset   = (st_r == ST_POR) || (st_r == ST_SLEEP);
   assign sleeping    = (st_r == ST_SLEEP);
   assign irq_discard = enter;

   // pins follow held state while release is set, except after a clear-pin wake, when they sit in reset state
   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : pin_g
         // after a clear-pin wake the pins sit in reset state until release
         wire master_clear_pin_g = rel_r && master_clear_pin_sleep_r && st_r == ST_RUN;
         wire hold_g = rel_r && !master_clear_pin_g;
         assign pin_oe[g]  = master_clear_pin_g ? 1'b0 : (hold_g ? ~hdir_r[g] : ~dir_r[g]);
         assign pin_out[g] = master_clear_pin_g ? 1'b0 : (hold_g ? hlat_r[g] : lat_r[g]);
      end
   endgenerate

   assign secondary_oscillator_enable = rel_r ? hsosc_r : secondary_oscillator_en_r;
   wire sel_osc_wdt = cfg_r[`DSX_C_WDTOSC];
   wire sel_osc_rtc = cfg_r[`DSX_C_CALENDAR_CLOCK_SELECT];
   assign secondary_oscillator_run = secondary_oscillator_enable || (sleeping && wdt_en && sel_osc_wdt) || sel_osc_rtc;
   assign low_power_rc_clock_run = (sleeping && wdt_en && !sel_osc_wdt) || !sel_osc_rtc;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= 16'h0000;
      end else if (bus_rd) begin
         case (bus_addr)
            `DSX_A_CTRL: bus_rdata <= {arm_r, 13'h0000, bor_r, rel_r};
            `DSX_A_WAKE: bus_rdata <= {7'h00, wake_r};
            `DSX_A_RST:  bus_rdata <= {5'h00, exit_r, 9'h000, porf_r};
            `DSX_A_GPR0: bus_rdata <= gpr0_r;
            `DSX_A_GPR1: bus_rdata <= gpr1_r;
            `DSX_A_CFG:  bus_rdata <= {8'h00, cfg_r};
            `DSX_A_DIR:  bus_rdata <= {{(16-NPIN){1'b0}}, dir_r};
            `DSX_A_LAT:  bus_rdata <= {{(16-NPIN){1'b0}}, lat_r};
            `DSX_A_CMD:  bus_rdata <= {15'h0000, secondary_oscillator_en_r};
            `DSX_A_STAT: bus_rdata <= {14'h0000, st_r};
            default:     bus_rdata <= 16'h0000;
         endcase
      end else begin
         bus_rdata <= 16'h0000;
      end
   end
endmodule

/* File: dsx_ctrl_props.sv */
// port assertions for the deep-sleep controller
// assumes one clock domain and the offsets of dsx_defs.vh
`include "dsx_defs.vh"
module dsx_ctrl_props #(
   parameter NPIN = 8
) (
   input wire logic            sys_clk,
   input wire logic            arst_n,
   input wire logic [3:0]      bus_addr,
   input wire logic [15:0]     bus_wdata,
   input wire logic            bus_wr,
   input wire logic            power_save,
   input wire logic            irq_discard,
   input wire logic            sleeping,
   input wire logic            cpu_reset,
   input wire logic            master_clear_n,
   input wire logic            brownout_event,
   input wire logic            supply_por,
   input wire logic [NPIN-1:0] pin_out,
   input wire logic [NPIN-1:0] pin_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire arm_wr = bus_wr && bus_addr == `DSX_A_CTRL && bus_wdata[`DSX_B_ARM] && !sleeping && !cpu_reset;
   // master_clear_pin and brown-out may move the pins, so the hold window excludes them
   wire quiet = sleeping && master_clear_n && !brownout_event && !supply_por;
   a_discard_entry: assert property ($rose(sleeping) |-> irq_discard || $past(irq_discard))
      else $error("no discard at entry");
   a_sleep_reset: assert property (sleeping |-> cpu_reset)
      else $error("cpu runs in sleep");
   a_pins_hold: assert property (quiet[*6] |-> $stable(pin_out) && $stable(pin_oe))
      else $error("pins moved in sleep");
   a_por_length: assert property ($fell(sleeping) |-> cpu_reset[*8] ##[1:30] !cpu_reset)
      else $error("bad wake reset length");
   a_por_no_wake: assert property (cpu_reset && !sleeping |=> !sleeping)
      else $error("wake taken during reset");
   a_arm_enter: assert property (arm_wr ##1 (!power_save)[*3] ##1 power_save |-> ##[0:2] sleeping)
      else $error("entry refused");
   a_arm_lapse: assert property (arm_wr ##1 (!power_save)[*5] ##1 power_save |=> !sleeping[*2])
      else $error("arm did not lapse");
   a_oe_reset: assert property ($rose(arst_n) |-> pin_oe == '0)
      else $error("pins driven after reset");
endmodule
bind dsx_ctrl dsx_ctrl_props #(.NPIN(NPIN)) i_props (.sys_clk(sys_clk), .arst_n(arst_n),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .power_save(power_save),
   .irq_discard(irq_discard), .sleeping(sleeping), .cpu_reset(cpu_reset), .master_clear_n(master_clear_n),
   .brownout_event(brownout_event), .supply_por(supply_por), .pin_out(pin_out), .pin_oe(pin_oe));

/* File: dsx_wake_src.sv */
// wake and reset pins seen by the deep-sleep controller
// assumes fire() is called at a rising clock edge
module dsx_wake_src (
   input  wire logic sys_clk,
   output logic      calendar_alarm,
   output logic      master_clear_n,
   output logic      external_wake_input,
   output logic      brownout_event,
   output logic      supply_por
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      calendar_alarm = 1'b0;
      master_clear_n = 1'b1;
      external_wake_input = 1'b0;
      brownout_event = 1'b0;
      supply_por = 1'b0;
   end
   // two cycles, wide enough for the two-flop synchroniser
   task automatic fire(input int k);
      calendar_alarm <= (k == 1);
      master_clear_n <= (k != 2);
      external_wake_input <= (k == 0);
      brownout_event <= (k == 4);
      repeat (2) @(posedge sys_clk);
      calendar_alarm <= 1'b0;
      master_clear_n <= 1'b1;
      external_wake_input <= 1'b0;
      brownout_event <= 1'b0;
   endtask
endmodule

/* File: tb_deep_sleep_exit_and_retention.sv */
// bench: entry, every wake cause except por, retention and pin release
// assumes dsx_wake_src drives the wake pins; checker bound to dsx_ctrl
`include "dsx_defs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_deep_sleep_exit_and_retention;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  bus_addr = 4'h0;
   logic [15:0] bus_wdata = 16'h0000;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic        power_save = 1'b0;
   logic        irq_pending = 1'b0;
   logic        wake_polarity = 1'b1;
   logic        wake_enable = 1'b1;
   logic        calendar_enable = 1'b1;
   wire  [15:0] bus_rdata;
   wire         irq_discard, sleeping, cpu_reset, secondary_oscillator_run, low_power_rc_clock_run, secondary_oscillator_enable;
   wire         calendar_alarm, master_clear_n, external_wake_input, brownout_event, supply_por;
   wire  [7:0]  pin_out, pin_oe;
   int          failures = 0;
   int          num_checks = 0;
   dsx_ctrl #(.NPIN(8), .WDT_BASE(4)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .power_save(power_save),
      .irq_pending(irq_pending), .irq_discard(irq_discard), .sleeping(sleeping), .cpu_reset(cpu_reset),
      .secondary_oscillator_run(secondary_oscillator_run), .low_power_rc_clock_run(low_power_rc_clock_run), .secondary_oscillator_enable(secondary_oscillator_enable), .calendar_alarm(calendar_alarm),
      .master_clear_n(master_clear_n), .external_wake_input(external_wake_input), .wake_polarity(wake_polarity),
      .wake_enable(wake_enable), .brownout_event(brownout_event), .supply_por(supply_por),
      .calendar_enable(calendar_enable), .pin_out(pin_out), .pin_oe(pin_oe));
   dsx_wake_src i_src (.sys_clk(sys_clk), .calendar_alarm(calendar_alarm), .master_clear_n(master_clear_n),
      .external_wake_input(external_wake_input), .brownout_event(brownout_event), .supply_por(supply_por));
   initial forever #25 sys_clk = ~sys_clk;
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      @(posedge sys_clk);
      d = bus_rdata;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      `CHK("register", e, v)
   endtask
   task automatic pchk(input logic [7:0] oe, input logic [7:0] out);
      @(negedge sys_clk);
      `CHK("pin_oe", oe, pin_oe)
      `CHK("pin_out", out, pin_out & oe)
      @(posedge sys_clk);
   endtask
   task automatic wait_run();
      int n;
      for (n = 0; n < 400 && (sleeping || cpu_reset); n++) @(posedge sys_clk);
      `CHK("cpu_reset", 1'b0, cpu_reset)
   endtask
   task automatic enter_sleep();
      wr(`DSX_A_CTRL, 16'h8000);
      repeat (2) @(posedge sys_clk);
      power_save <= 1'b1;
      @(posedge sys_clk);
      power_save <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK("sleeping", 1'b1, sleeping)
   endtask
   task automatic t_lapse();
      irq_pending <= 1'b1;
      wr(`DSX_A_CTRL, 16'h8000);
      repeat (4) @(posedge sys_clk);
      power_save <= 1'b1;
      @(posedge sys_clk);
      power_save <= 1'b0;
      irq_pending <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK("sleeping", 1'b0, sleeping)
      rchk(`DSX_A_CTRL, 16'h0000);
   endtask
   task automatic t_wake(input int k, input logic [15:0] flag);
      logic [15:0] v;
      wr(`DSX_A_CFG, (k == 3) ? 16'h0083 : 16'h0000);
      wr(`DSX_A_DIR, 16'h000f);
      wr(`DSX_A_LAT, 16'h00a5);
      enter_sleep();
      wr(`DSX_A_DIR, 16'h00ff);
      if (k != 3) i_src.fire(k);
      wait_run();
      rchk(`DSX_A_WAKE, flag);
      rchk(`DSX_A_CTRL, 16'h0001);
      rchk(`DSX_A_GPR0, 16'h5a3c);
      rd(`DSX_A_RST, v);
      `CHK("exit_flag", 1'b1, v[`DSX_B_EXIT])
      wr(`DSX_A_DIR, 16'h0000);
      pchk((k == 2) ? 8'h00 : 8'hf0, (k == 2) ? 8'h00 : 8'ha0);
      wr(`DSX_A_CTRL, 16'h0000);
      pchk(8'hff, 8'h00);
      wr(`DSX_A_RST, 16'h0000);
      rchk(`DSX_A_RST, 16'h0000);
   endtask
   task automatic t_bor();
      wr(`DSX_A_CFG, 16'h0040);
      enter_sleep();
      i_src.fire(4);
      @(posedge sys_clk);
      i_src.fire(2);
      wait_run();
      rchk(`DSX_A_WAKE, 16'h0000);
      rchk(`DSX_A_GPR0, 16'h0000);
      rchk(`DSX_A_CTRL, 16'h0002);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      results();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      rchk(`DSX_A_RST, 16'h0001);
      rchk(`DSX_A_DIR, 16'h00ff);
      rchk(4'hf, 16'h0000);
      wr(`DSX_A_GPR0, 16'h5a3c);
      t_lapse();
      t_wake(0, 16'h0100);
      t_wake(1, 16'h0008);
      t_wake(2, 16'h0004);
      t_wake(3, 16'h0010);
      t_bor();
      results();
   end
endmodule
